// ---- iot_regs.svh ----
// Notes on behaviour
// (RULE1) Thirty-two pins in four byte ports; pulled-up input, open-drain or push-pull.
// (RULE2) Any general-purpose pin can interrupt; all share one common vector.
// (RULE3) Current-sink pin written 1: sink off, pull-up drives high, usable as input.
// (RULE4) Current-sink pin written 0: pull-up off, sink on at programmed level.
// (RULE5) Each current-sink pin has its own register choosing one of sixteen levels.
// (RULE6) Current-sink pins 1:0 use the high range, pins 7:2 the low range.
// (RULE7) Current-sink pins interrupt with per-pin polarity on their own vector.
// (RULE8) Per-pin mask picks which current-sink pins feed their shared interrupt.
// (RULE9) Per-pin mask picks which general-purpose pins feed the port interrupt.
// (RULE10) General-purpose edge polarity is chosen per port in port configuration; here a separate polarity register at 0x09 holds it.
// (RULE11) Polarity selects rising 0-to-1 or falling 1-to-0 transitions.
// (RULE12) Internal 6 MHz and 12 MHz clocks derived internally, never on pins.
// (RULE13) On power-up all logic resets, then fetch starts at address zero.
// (RULE14) Watchdog not cleared for about 8 ms forces a hardware reset.
// (RULE15) Firmware clears the watchdog more often than its timeout.
// (RULE16) Eight individually maskable vectored interrupt sources.
// (RULE17) Timer 128 us and 1.024 ms taps interrupt on low-to-high toggle.
// (RULE18) Each of three endpoints interrupts after a packet is sent on it.
// (RULE19) Free-running 12-bit microsecond counter, never stopped or reloaded.
// (RULE20) Reading low byte latches upper nibble; upper reads return the latch.
// (RULE21) Timer low byte at 0x24, held nibble at 0x25, both read-only.
// (RULE22) Per-source enables live in read/write register at 0x20.
// (RULE23) General-purpose pin masks are write-only registers at 0x04 to 0x07.
// (RULE24) Current-sink enable write-only at 0x31, polarity write-only at 0x32.
// (RULE25) Pins synchronised before edge detection; one request per transition.
// (RULE26) Sources stay pending until vectored; masked sources never vector.
`ifndef IOT_REGS_SVH
`define IOT_REGS_SVH

// ****************************************
// timing
// ****************************************
`define IOT_CLK_HZ 32'h01312d00
`define IOT_CLK_MHZ 32'h00000014
`define IOT_TICK_HZ 32'h000f4240
`define IOT_US_CYC (`IOT_CLK_HZ / `IOT_TICK_HZ)
`define IOT_F6_MHZ 32'h00000006
`define IOT_F12_MHZ 32'h0000000c
`define IOT_WDT_MS 32'h00000008
`define IOT_MS_PER_S 32'h000003e8
`define IOT_WDT_CYC (`IOT_CLK_HZ / `IOT_MS_PER_S * `IOT_WDT_MS)
`define IOT_POR_HOLD_CYC 5'h10
`define IOT_TAP128_BIT 7
`define IOT_TAP1024_BIT 10

// ****************************************
// i/o addresses
// ****************************************
`define IOT_A_GPIO_DATA0 8'h00
`define IOT_A_GPIO_MASK0 8'h04
`define IOT_A_GPIO_CFG 8'h08
`define IOT_A_GPIO_POL 8'h09
`define IOT_A_GIE 8'h20
`define IOT_A_TMR_LO 8'h24
`define IOT_A_TMR_HI 8'h25
`define IOT_A_WDT_CLR 8'h26
`define IOT_A_DAC_DATA 8'h30
`define IOT_A_DAC_IE 8'h31
`define IOT_A_DAC_POL 8'h32
`define IOT_A_DAC_ISINK0 8'h38

// ****************************************
// reset values and source indices
// ****************************************
`define IOT_RST_GPIO_DATA 8'hff
`define IOT_RST_DAC_DATA 8'hff
`define IOT_HIGH_RANGE_PINS 8'h03
`define IOT_RST_ADDR 14'h0000
`define IOT_SRC_USBRST 3'h0
`define IOT_SRC_T128 3'h1
`define IOT_SRC_T1024 3'h2
`define IOT_SRC_EP0 3'h3
`define IOT_SRC_DAC 3'h6
`define IOT_SRC_GPIO 3'h7

`endif

// ---- iot_pkg.sv ----
package iot_pkg;
  // power-up sequencer states
  typedef enum logic [1:0] {
    PWR_HOLD = 2'b00,
    PWR_START = 2'b01,
    PWR_RUN = 2'b10
  } iot_pwr_t;
  // general-purpose port drive modes
  typedef enum logic [1:0] {
    GM_PULLIN = 2'b00,
    GM_OPEN = 2'b01,
    GM_PUSH = 2'b10,
    GM_RSVD = 2'b11
  } iot_gmode_t;
endpackage

// ---- iot_edge_det.sv ----
`timescale 1ns/1ps
module iot_edge_det import iot_pkg::*; #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pinIn,
  input wire logic [W-1:0] risePol,
  output logic [W-1:0] pinSync,
  output logic [W-1:0] edgePulse
);
  logic [W-1:0] meta_reg, sync_reg, prev_reg, pulse_reg;
  logic [W-1:0] pulse_next;

  // one-cycle pulse on the selected transition of the synchronised level
  always_comb begin
    pulse_next = (risePol & sync_reg & ~prev_reg) | (~risePol & ~sync_reg & prev_reg); // RULE11
  end

  // two-flop synchroniser, history stage and pulse register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
      pulse_reg <= '0;
    end else begin
      meta_reg <= pinIn; // RULE25
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      pulse_reg <= pulse_next;
    end
  end

  assign pinSync = sync_reg;
  assign edgePulse = pulse_reg;

  AST_EDGE_SINGLE: assert property (@(posedge clk) disable iff (!rst_n) // RULE25
    (edgePulse & $past(edgePulse)) == '0)
    else $error("edge pulse lasted two cycles");
endmodule // iot_edge_det

// ---- iot_timer.sv ----
`timescale 1ns/1ps
`include "iot_regs.svh"
module iot_timer import iot_pkg::*; #(
  parameter int US_CYC = `IOT_US_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic latchHi,
  output logic [11:0] count,
  output logic [3:0] hiHeld,
  output logic tap128Rise,
  output logic tap1024Rise
);
  localparam int PW = $clog2(US_CYC);
  localparam logic [PW-1:0] PRE_LAST = PW'(US_CYC - 1);
  logic [PW-1:0] pre_reg, pre_next;
  logic [11:0] cnt_reg, cnt_next;
  logic [3:0] hi_reg, hi_next;
  logic t128_reg, t128_next, t1024_reg, t1024_next;
  logic tick;

  // prescaler, counter, nibble latch and tap edges
  always_comb begin
    tick = (pre_reg == PRE_LAST);
    pre_next = tick ? '0 : pre_reg + 1'b1;
    cnt_next = tick ? cnt_reg + 12'h001 : cnt_reg; // RULE19
    hi_next = latchHi ? cnt_reg[11:8] : hi_reg; // RULE20
    t128_next = ~cnt_reg[`IOT_TAP128_BIT] & cnt_next[`IOT_TAP128_BIT]; // RULE17
    t1024_next = ~cnt_reg[`IOT_TAP1024_BIT] & cnt_next[`IOT_TAP1024_BIT];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= '0;
      cnt_reg <= 12'h000;
      hi_reg <= 4'h0;
      t128_reg <= 1'b0;
      t1024_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      hi_reg <= hi_next;
      t128_reg <= t128_next;
      t1024_reg <= t1024_next;
    end
  end

  assign count = cnt_reg;
  assign hiHeld = hi_reg;
  assign tap128Rise = t128_reg;
  assign tap1024Rise = t1024_reg;

  AST_TIMER_STEP: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
    (pre_reg == PRE_LAST) |=> (count == $past(count) + 12'h001))
    else $error("timer did not advance on tick");
  AST_TIMER_LATCH: assert property (@(posedge clk) disable iff (!rst_n) // RULE20
    latchHi |=> (hiHeld == $past(count[11:8])) ##1 (hiHeld == $past(hiHeld) || $past(latchHi)))
    else $error("held nibble wrong");
endmodule // iot_timer

// ---- iot_top.sv ----
`timescale 1ns/1ps
`include "iot_regs.svh"
module iot_top import iot_pkg::*; #(
  parameter int WDT_CYC = `IOT_WDT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] ioAddr,
  input wire logic [7:0] ioWrData,
  input wire logic ioWr,
  input wire logic ioRd,
  output logic [7:0] ioRdData,
  input wire logic [31:0] gpioIn,
  output logic [31:0] gpioOut,
  output logic [31:0] gpioOe,
  output logic [31:0] gpioPullupEn,
  input wire logic [7:0] dacIn,
  output logic [7:0] dacPullupEn,
  output logic [7:0] dacSinkEn,
  output logic [31:0] dacLevel,
  output logic [7:0] dacHighRange,
  input wire logic usbBusReset,
  input wire logic [2:0] epPacketDone,
  input wire logic cpuIntEnable,
  input wire logic intAck,
  output logic intReq,
  output logic [2:0] intVector,
  output logic wdtReset,
  output logic cpuRun,
  output logic startFetch,
  output logic [13:0] fetchAddr,
  output logic clk6Tick,
  output logic clk12Tick
);
  localparam int WW = $clog2(WDT_CYC);
  localparam logic [WW-1:0] WDT_LAST = WW'(WDT_CYC - 1);
  localparam logic [4:0] CLK_MHZ = 5'(`IOT_CLK_MHZ);

  // ****************************************
  // helper functions
  // ****************************************
  // pin drive as {out, oe, pullup} for a mode and written data bit
  function automatic logic [2:0] pinDrive(input logic [1:0] mode, input logic dataBit);
    unique case (iot_gmode_t'(mode))
      GM_PULLIN: pinDrive = {1'b0, ~dataBit, dataBit};
      GM_OPEN: pinDrive = {1'b0, ~dataBit, 1'b0};
      GM_PUSH: pinDrive = {dataBit, 1'b1, 1'b0};
      default: pinDrive = {1'b0, 1'b0, 1'b1};
    endcase
  endfunction

  // fractional-rate strobe step: {tick, new phase}
  function automatic logic [5:0] phaseStep(input logic [4:0] ph, input logic [4:0] inc);
    logic [5:0] sum;
    sum = {1'b0, ph} + {1'b0, inc};
    if (sum >= {1'b0, CLK_MHZ}) begin
      phaseStep = {1'b1, 5'(sum - {1'b0, CLK_MHZ})};
    end else begin
      phaseStep = {1'b0, sum[4:0]};
    end
  endfunction

  // ****************************************
  // sub-blocks
  // ****************************************
  logic [7:0] gpioData_reg [4], gpioData_next [4];
  logic [7:0] gpioMask_reg [4], gpioMask_next [4];
  logic [7:0] gpioCfg_reg, gpioCfg_next;
  logic [3:0] gpioPol_reg, gpioPol_next;
  logic [7:0] dacData_reg, dacData_next;
  logic [7:0] dacIe_reg, dacIe_next;
  logic [7:0] dacPol_reg, dacPol_next;
  logic [3:0] dacLvl_reg [8], dacLvl_next [8];
  logic [7:0] gie_reg, gie_next;
  logic [31:0] gpioPol32, gpioSync, gpioEdge, gpioMask32;
  logic [7:0] dacSync, dacEdge;
  logic [11:0] tmrCount;
  logic [3:0] tmrHi;
  logic tap128, tap1024;
  logic latchHi, wdtClr;

  // rising polarity spread from each port to its eight pins
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      gpioPol32[p*8 +: 8] = {8{gpioPol_reg[p]}}; // RULE10
      gpioMask32[p*8 +: 8] = gpioMask_reg[p];
    end
  end

  iot_edge_det #(.W(32)) uGpioEdge (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(gpioIn),
    .risePol(gpioPol32),
    .pinSync(gpioSync),
    .edgePulse(gpioEdge)
  );

  iot_edge_det #(.W(8)) uDacEdge (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(dacIn),
    .risePol(dacPol_reg),
    .pinSync(dacSync),
    .edgePulse(dacEdge)
  );

  iot_timer uTimer (
    .clk(clk),
    .rst_n(rst_n),
    .latchHi(latchHi),
    .count(tmrCount),
    .hiHeld(tmrHi),
    .tap128Rise(tap128),
    .tap1024Rise(tap1024)
  );

  // ****************************************
  // register writes
  // ****************************************
  always_comb begin
    gpioCfg_next = gpioCfg_reg;
    gpioPol_next = gpioPol_reg;
    dacData_next = dacData_reg;
    dacIe_next = dacIe_reg;
    dacPol_next = dacPol_reg;
    gie_next = gie_reg;
    for (int p = 0; p < 4; p++) begin
      gpioData_next[p] = gpioData_reg[p];
      gpioMask_next[p] = gpioMask_reg[p];
      if (ioWr && ioAddr == `IOT_A_GPIO_DATA0 + 8'(p)) gpioData_next[p] = ioWrData;
      if (ioWr && ioAddr == `IOT_A_GPIO_MASK0 + 8'(p)) gpioMask_next[p] = ioWrData; // RULE23
    end
    for (int i = 0; i < 8; i++) begin
      dacLvl_next[i] = dacLvl_reg[i];
      if (ioWr && ioAddr == `IOT_A_DAC_ISINK0 + 8'(i)) dacLvl_next[i] = ioWrData[3:0]; // RULE5
    end
    if (ioWr) begin
      unique case (ioAddr)
        `IOT_A_GPIO_CFG: gpioCfg_next = ioWrData;
        `IOT_A_GPIO_POL: gpioPol_next = ioWrData[3:0];
        `IOT_A_DAC_DATA: dacData_next = ioWrData;
        `IOT_A_DAC_IE: dacIe_next = ioWrData; // RULE24
        `IOT_A_DAC_POL: dacPol_next = ioWrData;
        `IOT_A_GIE: gie_next = ioWrData; // RULE22
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < 4; p++) begin
        gpioData_reg[p] <= `IOT_RST_GPIO_DATA;
        gpioMask_reg[p] <= 8'h00;
      end
      for (int i = 0; i < 8; i++) dacLvl_reg[i] <= 4'h0;
      gpioCfg_reg <= 8'h00;
      gpioPol_reg <= 4'h0;
      dacData_reg <= `IOT_RST_DAC_DATA;
      dacIe_reg <= 8'h00;
      dacPol_reg <= 8'h00;
      gie_reg <= 8'h00;
    end else begin
      for (int p = 0; p < 4; p++) begin
        gpioData_reg[p] <= gpioData_next[p];
        gpioMask_reg[p] <= gpioMask_next[p];
      end
      for (int i = 0; i < 8; i++) dacLvl_reg[i] <= dacLvl_next[i];
      gpioCfg_reg <= gpioCfg_next;
      gpioPol_reg <= gpioPol_next;
      dacData_reg <= dacData_next;
      dacIe_reg <= dacIe_next;
      dacPol_reg <= dacPol_next;
      gie_reg <= gie_next;
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  logic [31:0] gOut_next, gOe_next, gPu_next, dacLevel_next;
  logic [31:0] gOut_reg, gOe_reg, gPu_reg, dacLevel_reg;
  logic [7:0] dPu_reg, dSink_reg, dHigh_reg;

  // each pin takes its port mode and its written data bit
  always_comb begin
    for (int n = 0; n < 32; n++) begin
      {gOut_next[n], gOe_next[n], gPu_next[n]} =
        pinDrive(gpioCfg_reg[(n/8)*2 +: 2], gpioData_reg[n/8][n%8]); // RULE1
    end
    for (int i = 0; i < 8; i++) dacLevel_next[i*4 +: 4] = dacLvl_reg[i];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gOut_reg <= 32'h00000000;
      gOe_reg <= 32'h00000000;
      gPu_reg <= 32'h00000000;
      dacLevel_reg <= 32'h00000000;
      dPu_reg <= 8'h00;
      dSink_reg <= 8'h00;
      dHigh_reg <= `IOT_HIGH_RANGE_PINS; // RULE6
    end else begin
      gOut_reg <= gOut_next;
      gOe_reg <= gOe_next;
      gPu_reg <= gPu_next;
      dacLevel_reg <= dacLevel_next;
      dPu_reg <= dacData_next; // RULE3
      dSink_reg <= ~dacData_next; // RULE4
      dHigh_reg <= `IOT_HIGH_RANGE_PINS;
    end
  end

  // ****************************************
  // interrupt controller
  // ****************************************
  logic [7:0] srcEvt, ackMask, pend_reg, pend_next, enabledPend;
  logic intReq_reg, intReq_next;
  logic [2:0] intVec_reg, intVec_next;
  logic gpioHit, dacHit;

  // sources latch, the presented one clears on acknowledge, set wins
  always_comb begin
    gpioHit = |(gpioEdge & gpioMask32); // RULE2 RULE9
    dacHit = |(dacEdge & dacIe_reg); // RULE7 RULE8
    srcEvt = {gpioHit, dacHit, epPacketDone, tap1024, tap128, usbBusReset}; // RULE16 RULE18
    ackMask = 8'h00;
    if (intAck && intReq_reg) ackMask[intVec_reg] = 1'b1;
    pend_next = (pend_reg & ~ackMask) | srcEvt; // RULE26
    enabledPend = pend_next & gie_reg;
    intReq_next = cpuIntEnable && (enabledPend != 8'h00);
    intVec_next = intVec_reg;
    for (int s = 7; s >= 0; s--) begin
      if (enabledPend[s]) intVec_next = 3'(s);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 8'h00;
      intReq_reg <= 1'b0;
      intVec_reg <= 3'h0;
    end else begin
      pend_reg <= pend_next;
      intReq_reg <= intReq_next;
      intVec_reg <= intVec_next;
    end
  end

  // ****************************************
  // power-up sequencer, watchdog, clock strobes
  // ****************************************
  iot_pwr_t pwr_reg, pwr_next;
  logic [4:0] por_reg, por_next, ph6_reg, ph6_next, ph12_reg, ph12_next;
  logic [WW-1:0] wdt_reg, wdt_next;
  logic wdtFire_reg, wdtFire_next, start_reg, start_next, run_reg, run_next;
  logic t6_reg, t6_next, t12_reg, t12_next;

  always_comb begin
    wdtClr = ioWr && ioAddr == `IOT_A_WDT_CLR;
    pwr_next = pwr_reg;
    por_next = por_reg;
    wdt_next = wdt_reg;
    wdtFire_next = 1'b0;
    unique case (pwr_reg)
      PWR_HOLD: begin
        por_next = por_reg + 5'h01;
        if (por_reg == `IOT_POR_HOLD_CYC - 5'h01) pwr_next = PWR_START; // RULE13
      end
      PWR_START: begin
        por_next = 5'h00;
        wdt_next = '0;
        pwr_next = PWR_RUN;
      end
      PWR_RUN: begin
        if (wdtClr) begin
          wdt_next = '0;
        end else if (wdt_reg == WDT_LAST) begin
          wdtFire_next = 1'b1; // RULE14
          pwr_next = PWR_HOLD;
        end else begin
          wdt_next = wdt_reg + 1'b1;
        end
      end
      default: pwr_next = PWR_HOLD;
    endcase
    start_next = pwr_next == PWR_START;
    run_next = pwr_next == PWR_RUN;
    {t6_next, ph6_next} = phaseStep(ph6_reg, 5'(`IOT_F6_MHZ)); // RULE12
    {t12_next, ph12_next} = phaseStep(ph12_reg, 5'(`IOT_F12_MHZ));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_reg <= PWR_HOLD;
      por_reg <= 5'h00;
      wdt_reg <= '0;
      wdtFire_reg <= 1'b0;
      start_reg <= 1'b0;
      run_reg <= 1'b0;
      ph6_reg <= 5'h00;
      ph12_reg <= 5'h00;
      t6_reg <= 1'b0;
      t12_reg <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      por_reg <= por_next;
      wdt_reg <= wdt_next;
      wdtFire_reg <= wdtFire_next;
      start_reg <= start_next;
      run_reg <= run_next;
      ph6_reg <= ph6_next;
      ph12_reg <= ph12_next;
      t6_reg <= t6_next;
      t12_reg <= t12_next;
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  logic [7:0] rd_reg, rd_next;

  always_comb begin
    latchHi = ioRd && ioAddr == `IOT_A_TMR_LO; // RULE20
    rd_next = rd_reg;
    if (ioRd) begin
      rd_next = 8'h00;
      for (int p = 0; p < 4; p++) begin
        if (ioAddr == `IOT_A_GPIO_DATA0 + 8'(p)) rd_next = gpioSync[p*8 +: 8];
      end
      unique case (ioAddr)
        `IOT_A_GIE: rd_next = gie_reg;
        `IOT_A_TMR_LO: rd_next = tmrCount[7:0]; // RULE21
        `IOT_A_TMR_HI: rd_next = {4'h0, tmrHi};
        `IOT_A_DAC_DATA: rd_next = dacSync;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rd_reg <= 8'h00;
    else rd_reg <= rd_next;
  end

  // outputs, all straight from flip-flops except fetchAddr, which is tied to the constant reset address
  assign ioRdData = rd_reg;
  assign gpioOut = gOut_reg;
  assign gpioOe = gOe_reg;
  assign gpioPullupEn = gPu_reg;
  assign dacPullupEn = dPu_reg;
  assign dacSinkEn = dSink_reg;
  assign dacLevel = dacLevel_reg;
  assign dacHighRange = dHigh_reg;
  assign intReq = intReq_reg;
  assign intVector = intVec_reg;
  assign wdtReset = wdtFire_reg;
  assign cpuRun = run_reg;
  assign startFetch = start_reg;
  assign fetchAddr = `IOT_RST_ADDR;
  assign clk6Tick = t6_reg;
  assign clk12Tick = t12_reg;

  // ****************************************
  // assertions
  // ****************************************
  AST_DAC_DRIVE: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    (ioWr && ioAddr == `IOT_A_DAC_DATA) |=>
      (dacPullupEn == $past(ioWrData) && dacSinkEn == ~$past(ioWrData)))
    else $error("current-sink drive does not follow written data");
  AST_DAC_LEVEL: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    (ioWr && ioAddr == `IOT_A_DAC_ISINK0) |=> ##1 (dacLevel[3:0] == $past(ioWrData[3:0], 2)))
    else $error("sink level of pin 0 not taken");
  AST_GPIO_PEND: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    ((gpioEdge & gpioMask32) != 32'h00000000) |=> pend_reg[`IOT_SRC_GPIO])
    else $error("masked-in pin edge did not pend");
  AST_DAC_MASKED: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    (!pend_reg[`IOT_SRC_DAC] && (dacEdge & dacIe_reg) == 8'h00)
      |=> !pend_reg[`IOT_SRC_DAC])
    else $error("current-sink interrupt pended without enabled edge");
  AST_TAP_PEND: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
    (tap128 || tap1024) |=> (pend_reg[`IOT_SRC_T128] || pend_reg[`IOT_SRC_T1024]))
    else $error("timer tap did not pend");
  AST_NO_MASKED_VECTOR: assert property (@(posedge clk) disable iff (!rst_n) // RULE26
    intReq |-> ($past(cpuIntEnable) && gie_reg[intVector] == $past(gie_reg[intVector])
      ? gie_reg[intVector] && pend_reg[intVector] : pend_reg[intVector]))
    else $error("vector presented for a masked or idle source");
  AST_PEND_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RULE26
    (pend_reg[`IOT_SRC_EP0] && !(intAck && intReq && intVector == `IOT_SRC_EP0))
      |=> pend_reg[`IOT_SRC_EP0])
    else $error("pending source dropped without acknowledge");
  AST_WDT_FIRE: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
    (pwr_reg == PWR_RUN && wdt_reg == WDT_LAST && !wdtClr) |=> (wdtReset && !cpuRun))
    else $error("watchdog expiry gave no reset");
  AST_POR_START: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
    $rose(cpuRun) |-> ($past(startFetch) && fetchAddr == `IOT_RST_ADDR))
    else $error("run began without fetch at address zero");
endmodule // iot_top

// ---- iot_cpu_model.sv ----
`timescale 1ns/1ps
// ****
// processor core model
// ****
module iot_cpu_model (
  input wire logic clk,
  input wire logic [7:0] ioRdData,
  output logic [7:0] ioAddr,
  output logic [7:0] ioWrData,
  output logic ioWr,
  output logic ioRd,
  output logic intAck
);
  // idle bus at time zero
  initial begin
    ioAddr = 8'h00;
    ioWrData = 8'h00;
    ioWr = 1'b0;
    ioRd = 1'b0;
    intAck = 1'b0;
  end
  // one strobe held across a rising edge, then released
  task automatic cyc(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge clk);
    ioAddr = a;
    ioWrData = d;
    ioWr = w;
    ioRd = ~w;
    @(negedge clk);
    ioWr = 1'b0;
    ioRd = 1'b0;
    ioAddr = ~a; // released address does not keep its value
    ioWrData = ~d;
  endtask
  // write followed by a watchdog clear
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(a, d, 1'b1);
    cyc(8'h26, 8'h00, 1'b1);
  endtask
  // read and take the registered answer
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    cyc(a, 8'h00, 1'b0);
    @(negedge clk);
    d = ioRdData;
  endtask
  // acknowledge the presented vector
  task automatic ack();
    @(negedge clk);
    intAck = 1'b1;
    @(negedge clk);
    intAck = 1'b0;
  endtask
endmodule // iot_cpu_model

// ---- io_timer_interrupt_subsystem_tb_top.sv ----
`timescale 1ns/1ps
module io_timer_interrupt_subsystem_tb_top;
  typedef struct {logic [7:0] d; logic [7:0] pu; logic [7:0] sk;} iot_row_t;
  iot_row_t rows [4] = '{'{8'hff, 8'hff, 8'h00}, '{8'h00, 8'h00, 8'hff},
    '{8'ha5, 8'ha5, 8'h5a}, '{8'h0f, 8'h0f, 8'hf0}};
  logic clk = 1'b0, rst_n = 1'b0, usbBusReset = 1'b0, cpuIntEnable = 1'b1;
  logic [31:0] gpioIn = 32'h00000000;
  logic [7:0] dacIn = 8'hff, ioAddr, ioWrData, ioRdData, dacPullupEn, dacSinkEn, dacHighRange;
  logic [2:0] epPacketDone = 3'h0, intVector;
  logic ioWr, ioRd, intAck, intReq, wdtReset, cpuRun, startFetch, clk6Tick, clk12Tick;
  logic [31:0] gpioOut, gpioOe, gpioPullupEn, dacLevel;
  logic [13:0] fetchAddr;
  logic [7:0] v, h;
  int num_errors = 0, checked = 0, cycles = 0;
  iot_top #(.WDT_CYC(4000)) u_dut (.clk(clk), .rst_n(rst_n), .ioAddr(ioAddr),
    .ioWrData(ioWrData), .ioWr(ioWr), .ioRd(ioRd), .ioRdData(ioRdData), .gpioIn(gpioIn),
    .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioPullupEn(gpioPullupEn), .dacIn(dacIn),
    .dacPullupEn(dacPullupEn), .dacSinkEn(dacSinkEn), .dacLevel(dacLevel),
    .dacHighRange(dacHighRange), .usbBusReset(usbBusReset), .epPacketDone(epPacketDone),
    .cpuIntEnable(cpuIntEnable), .intAck(intAck), .intReq(intReq), .intVector(intVector),
    .wdtReset(wdtReset), .cpuRun(cpuRun), .startFetch(startFetch), .fetchAddr(fetchAddr),
    .clk6Tick(clk6Tick), .clk12Tick(clk12Tick));
  iot_cpu_model u_cpu (.clk(clk), .ioRdData(ioRdData), .ioAddr(ioAddr),
    .ioWrData(ioWrData), .ioWr(ioWr), .ioRd(ioRd), .intAck(intAck));
  // ****
  // helpers
  // ****
  initial begin
    forever #25 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bounded wait for a high level
  task automatic wait_hi(ref logic s, input int lim);
    for (int n = 0; n < lim && s !== 1'b1; n++) @(negedge clk);
  endtask
  // one-cycle event pulse on source s
  task automatic pulse(input int s);
    @(negedge clk);
    if (s == 0) usbBusReset = 1'b1;
    else epPacketDone[s-3] = 1'b1;
    @(negedge clk);
    usbBusReset = 1'b0;
    epPacketDone = 3'h0;
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (3) @(negedge clk);
    chk("hirange", dacHighRange, 32'h03);
    chk("run_rst", cpuRun, 32'h0);
    rst_n = 1'b1;
    wait_hi(cpuRun, 30);
    chk("run", cpuRun, 32'h1);
    chk("fetch", fetchAddr, 32'h0);
    chk("gpu", gpioPullupEn, 32'hffffffff);
    u_cpu.wr(8'h08, 8'h02);
    u_cpu.wr(8'h00, 8'h5a);
    chk("gout", {gpioOe[7:0], gpioOut[7:0]}, 32'hff5a);
    v = 8'h00;
    h = 8'h00;
    repeat (20) begin
      @(negedge clk);
      v = v + {7'h00, clk6Tick};
      h = h + {7'h00, clk12Tick};
    end
    chk("tick6", v, 32'h6);
    chk("tick12", h, 32'h0c);
    foreach (rows[i]) begin
      u_cpu.wr(8'h30, rows[i].d);
      chk("pullup", dacPullupEn, rows[i].pu);
      chk("sink", dacSinkEn, rows[i].sk);
    end
    for (int i = 0; i < 8; i++) begin
      u_cpu.wr(8'h38 + i[7:0], 8'h08 + i[7:0]);
      chk("level", dacLevel[4*i+:4], 32'h08 + i);
    end
    u_cpu.rd(8'h04, v);
    chk("mask_wo", v, 32'h0);
    u_cpu.wr(8'h20, 8'h80);
    u_cpu.rd(8'h20, v);
    chk("gie", v, 32'h80);
    u_cpu.wr(8'h04, 8'h01);
    u_cpu.wr(8'h09, 8'h01);
    gpioIn[1] = 1'b1;
    repeat (10) @(negedge clk);
    chk("masked", intReq, 32'h0);
    gpioIn[0] = 1'b1;
    wait_hi(intReq, 10);
    chk("gpio_vec", {intReq, intVector}, 32'hf);
    u_cpu.ack();
    repeat (2) @(negedge clk);
    chk("acked", intReq, 32'h0);
    gpioIn[0] = 1'b0;
    repeat (10) @(negedge clk);
    chk("wrong_edge", intReq, 32'h0);
    u_cpu.wr(8'h20, 8'h40);
    u_cpu.wr(8'h31, 8'h01);
    u_cpu.wr(8'h32, 8'h00);
    dacIn[0] = 1'b0;
    wait_hi(intReq, 10);
    chk("dac_vec", {intReq, intVector}, 32'he);
    u_cpu.ack();
    for (int k = 0; k < 4; k++) begin
      u_cpu.wr(8'h20, 8'h01 << (k == 0 ? 0 : k + 2));
      pulse(k == 0 ? 0 : k + 2);
      wait_hi(intReq, 10);
      chk("src_vec", {intReq, intVector}, 32'h8 + (k == 0 ? 0 : k + 2));
      u_cpu.ack();
    end
    u_cpu.wr(8'h20, 8'h02);
    wait_hi(intReq, 2700);
    chk("tap_vec", {intReq, intVector}, 32'h9);
    u_cpu.wr(8'h20, 8'h00);
    u_cpu.ack();
    u_cpu.rd(8'h24, v);
    repeat (400) @(negedge clk);
    u_cpu.rd(8'h25, h);
    chk("hi_pad", h & 8'hf0, 32'h0);
    repeat (400) @(negedge clk);
    u_cpu.rd(8'h25, v);
    chk("hi_held", v, h);
    wait_hi(wdtReset, 4100);
    chk("wdt", wdtReset, 32'h1);
    repeat (2) @(negedge clk);
    chk("wdt_halt", cpuRun, 32'h0);
    wait_hi(startFetch, 30);
    chk("refetch", startFetch, 32'h1);
    end_sim();
  end
endmodule // io_timer_interrupt_subsystem_tb_top
